// ---- core/pifp_defines.vh ----
`ifndef PIFP_DEFINES_VH
`define PIFP_DEFINES_VH

// register indices; byte address is four times the index
`define PIFP_IDX_PORT_C_INPUT_ENABLE        16'h30ba
`define PIFP_IDX_PORT_FILTER_SELECT_PORTS   16'h30ec
`define PIFP_IDX_FILTER_CLOCK_DIVIDER       16'h30ed
`define PIFP_IDX_PORT_FILTER_SELECT_SPECIAL 16'h30ee
`define PIFP_IDX_PORT_A_PULLUP_ENABLE       16'h30f0

`define PIFP_ADDR_W 18

// reset values
`define PIFP_RST_PORT_C_INPUT_ENABLE        4'h0
`define PIFP_RST_PORT_FILTER_SELECT_PORTS   6'h00
`define PIFP_RST_PORT_FILTER_SELECT_SPECIAL 4'h0
`define PIFP_RST_FILTER_CLOCK_DIVIDER       8'h00
`define PIFP_RST_PORT_A_PULLUP_ENABLE       6'h00

// pin synchroniser reset: reset/irq pin (bit 19) idles high
`define PIFP_RST_PIN_SYNC 21'h08_0000

// port_c_input_enable fields
`define PIFP_PCIE_MSB 3
`define PIFP_PCIE_LSB 0

// port_filter_select_ports fields
`define PIFP_PORT_C_FILTER_SEL_MSB 5
`define PIFP_PORT_C_FILTER_SEL_LSB 4
`define PIFP_PORT_B_FILTER_SEL_MSB 3
`define PIFP_PORT_B_FILTER_SEL_LSB 2
`define PIFP_PORT_A_FILTER_SEL_MSB 1
`define PIFP_PORT_A_FILTER_SEL_LSB 0

// port_filter_select_special fields
`define PIFP_FLTKB_MSB 3
`define PIFP_FLTKB_LSB 2
`define PIFP_FLTRS_MSB 1
`define PIFP_FLTRS_LSB 0

// filter_clock_divider fields
`define PIFP_DIV3_MSB 7
`define PIFP_DIV3_LSB 5
`define PIFP_DIV2_MSB 4
`define PIFP_DIV2_LSB 2
`define PIFP_DIV1_MSB 1
`define PIFP_DIV1_LSB 0

// port_a_pullup_enable: bit 4 reserved
`define PIFP_PULL_MASK 6'h2f

// filter clock select codes
`define PIFP_FSEL_BUS  2'h0
`define PIFP_FSEL_DIV1 2'h1
`define PIFP_FSEL_DIV2 2'h2
`define PIFP_FSEL_DIV3 2'h3

// divider base masks (divide-by minus one at the top code)
`define PIFP_DIV1_MASK_TOP 12'h00f
`define PIFP_DIV2_MASK_TOP 12'hfff
`define PIFP_DIV3_MASK_TOP 7'h7f
`define PIFP_DIV1_CODE_TOP 2'h3
`define PIFP_DIV23_CODE_TOP 3'h7

`endif

// ---- core/pifp_filter.v ----
`timescale 1ns/100ps
// glitch filter for a group of pins sharing one filter clock
module pifp_filter #(
  parameter          WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input  wire             core_clk_in,
  input  wire             rst_in,
  input  wire [WIDTH-1:0] din_in,
  input  wire             tick_in,
  input  wire             bypass_in,
  output wire [WIDTH-1:0] dout_out
);

  reg [WIDTH-1:0] out_q;
  reg [WIDTH-1:0] seen_q;
  integer         i;

  // a new level must be seen on two consecutive ticks before it passes
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_q  <= INIT;
      seen_q <= {WIDTH{1'b0}};
    end else if (bypass_in) begin
      out_q  <= din_in;
      seen_q <= {WIDTH{1'b0}};
    end else if (tick_in) begin
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (din_in[i] == out_q[i]) begin
          seen_q[i] <= 1'b0;
        end else if (seen_q[i]) begin
          out_q[i]  <= din_in[i];
          seen_q[i] <= 1'b0;
        end else begin
          seen_q[i] <= 1'b1;
        end
      end
    end
  end

  assign dout_out = out_q;

endmodule // pifp_filter

// ---- core/pifp_top.v ----
`timescale 1ns/100ps
`include "pifp_defines.vh"

module pifp_top (
  input  wire                    core_clk_in,
  input  wire                    rst_in,
  input  wire                    psel_in,
  input  wire                    penable_in,
  input  wire                    pwrite_in,
  input  wire [`PIFP_ADDR_W-1:0] paddr_in,
  input  wire [31:0]             pwdata_in,
  input  wire [3:0]              pstrb_in,
  output wire [31:0]             prdata_out,
  output wire                    pready_out,
  output wire                    pslverr_out,
  input  wire                    stop_mode_in,
  input  wire                    lpo_clk_in,
  input  wire [5:0]              port_a_pin_in,
  input  wire [7:0]              port_b_pin_in,
  input  wire [3:0]              port_c_pin_in,
  input  wire                    kbi_pin_in,
  input  wire                    reset_irq_pin_in,
  input  wire [5:0]              port_a_out_en_in,
  input  wire [5:0]              port_a_in_en_in,
  output wire [5:0]              port_a_in_out,
  output wire [7:0]              port_b_in_out,
  output wire [3:0]              port_c_in_out,
  output wire                    keyboard_irq_in_out,
  output wire                    reset_irq_in_out,
  output wire [3:0]              port_c_in_en_out,
  output wire [5:0]              port_a_pull_out
);

  localparam [`PIFP_ADDR_W-1:0] ADDR_PCIE = {`PIFP_IDX_PORT_C_INPUT_ENABLE, 2'b00};
  localparam [`PIFP_ADDR_W-1:0] ADDR_FSP  = {`PIFP_IDX_PORT_FILTER_SELECT_PORTS, 2'b00};
  localparam [`PIFP_ADDR_W-1:0] ADDR_FDIV = {`PIFP_IDX_FILTER_CLOCK_DIVIDER, 2'b00};
  localparam [`PIFP_ADDR_W-1:0] ADDR_FSS  = {`PIFP_IDX_PORT_FILTER_SELECT_SPECIAL, 2'b00};
  localparam [`PIFP_ADDR_W-1:0] ADDR_PAPE = {`PIFP_IDX_PORT_A_PULLUP_ENABLE, 2'b00};

  // register file
  reg  [3:0]  port_c_input_enable_q;
  reg  [5:0]  port_filter_select_ports_q;
  reg  [3:0]  port_filter_select_special_q;
  reg  [7:0]  filter_clock_divider_q;
  reg  [5:0]  port_a_pullup_enable_q;

  // apb answer
  reg  [31:0] prdata_q;
  reg         pslverr_q;
  reg  [31:0] rdata_d;
  reg         hit_d;

  wire        setup_ph = psel_in & ~penable_in;
  wire        access_ph = psel_in & penable_in;
  // a refused address must not write; pstrb bit 0 gates the only
  // byte lane that holds register bits
  wire        wr_en = access_ph & pwrite_in & pstrb_in[0] & ~pslverr_q;

  // read mux and decode; reserved bits are zero-padded
  always @* begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b1;
    case (paddr_in)
      ADDR_PCIE: rdata_d = {28'h000_0000, port_c_input_enable_q};
      ADDR_FSP:  rdata_d = {26'h000_0000, port_filter_select_ports_q};
      ADDR_FDIV: rdata_d = {24'h00_0000, filter_clock_divider_q};
      ADDR_FSS:  rdata_d = {28'h000_0000, port_filter_select_special_q};
      ADDR_PAPE: rdata_d = {26'h000_0000, port_a_pullup_enable_q};
      default:   hit_d   = 1'b0;
    endcase
  end

  // answer is captured at setup so data comes from flip-flops in access
  // pslverr is latched there too, so the access cycle sees a stable flag
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q  <= pwrite_in ? 32'h0000_0000 : rdata_d;
      pslverr_q <= ~hit_d;
    end
  end

  // zero wait states: every register answers in its first access cycle
  assign pready_out  = 1'b1;
  assign pslverr_out = access_ph & pslverr_q;
  assign prdata_out  = access_ph ? prdata_q : 32'h0000_0000;

  // register writes; only byte lane 0 carries data
  // reserved bits are never stored, so they always read back as zero
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_c_input_enable_q        <= `PIFP_RST_PORT_C_INPUT_ENABLE;
      port_filter_select_ports_q   <= `PIFP_RST_PORT_FILTER_SELECT_PORTS;
      port_filter_select_special_q <= `PIFP_RST_PORT_FILTER_SELECT_SPECIAL;
      filter_clock_divider_q       <= `PIFP_RST_FILTER_CLOCK_DIVIDER;
      port_a_pullup_enable_q       <= `PIFP_RST_PORT_A_PULLUP_ENABLE;
    end else if (wr_en) begin
      case (paddr_in)
        ADDR_PCIE: port_c_input_enable_q <= pwdata_in[`PIFP_PCIE_MSB:`PIFP_PCIE_LSB];
        ADDR_FSP:  port_filter_select_ports_q <= pwdata_in[5:0];
        ADDR_FDIV: filter_clock_divider_q <= pwdata_in[7:0];
        ADDR_FSS:  port_filter_select_special_q <= pwdata_in[3:0];
        ADDR_PAPE: port_a_pullup_enable_q <= pwdata_in[5:0] & `PIFP_PULL_MASK;
        default: begin
        end
      endcase
    end
  end

  // field views
  wire [1:0] port_c_filter_sel = port_filter_select_ports_q[`PIFP_PORT_C_FILTER_SEL_MSB:`PIFP_PORT_C_FILTER_SEL_LSB];
  wire [1:0] port_b_filter_sel = port_filter_select_ports_q[`PIFP_PORT_B_FILTER_SEL_MSB:`PIFP_PORT_B_FILTER_SEL_LSB];
  wire [1:0] port_a_filter_sel = port_filter_select_ports_q[`PIFP_PORT_A_FILTER_SEL_MSB:`PIFP_PORT_A_FILTER_SEL_LSB];
  wire [1:0] keyboard_irq_filter_sel =
    port_filter_select_special_q[`PIFP_FLTKB_MSB:`PIFP_FLTKB_LSB];
  wire [1:0] reset_irq_pin_filter_sel =
    port_filter_select_special_q[`PIFP_FLTRS_MSB:`PIFP_FLTRS_LSB];
  wire [2:0] divider_set_three = filter_clock_divider_q[`PIFP_DIV3_MSB:`PIFP_DIV3_LSB];
  wire [2:0] divider_set_two   = filter_clock_divider_q[`PIFP_DIV2_MSB:`PIFP_DIV2_LSB];
  wire [1:0] divider_set_one   = filter_clock_divider_q[`PIFP_DIV1_MSB:`PIFP_DIV1_LSB];

  // synchronisers: first stage feeds only the second
  // lpo rides with the pins so it gets the same two-flop treatment
  reg  [20:0] sync1_q;
  reg  [20:0] sync2_q;
  reg         lpo_prev_q;
  wire [20:0] raw_pins = {lpo_clk_in, reset_irq_pin_in, kbi_pin_in,
                          port_c_pin_in, port_b_pin_in, port_a_pin_in};

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      // reset/irq pin idles high: resetting its stages low would let the
      // bypassed filter show a false low pulse right after reset
      sync1_q    <= `PIFP_RST_PIN_SYNC;
      sync2_q    <= `PIFP_RST_PIN_SYNC;
      lpo_prev_q <= 1'b0;
    end else begin
      sync1_q    <= raw_pins;
      sync2_q    <= sync1_q;
      lpo_prev_q <= sync2_q[20];
    end
  end

  wire [5:0] pa_sync  = sync2_q[5:0];
  wire [7:0] pb_sync  = sync2_q[13:6];
  wire [3:0] pc_sync  = sync2_q[17:14];
  wire       kbi_sync = sync2_q[18];
  wire       rst_sync = sync2_q[19];
  wire       lpo_rise = sync2_q[20] & ~lpo_prev_q;

  // limitation: ticks follow free-running counters, so the first filter
  // period after a divider change can be short by up to one period
  // filter clock dividers as tick strobes off free-running counters
  reg  [11:0] bus_cnt_q;
  reg  [6:0]  lpo_cnt_q;
  // each mask is all ones, one count short of the divide ratio
  wire [11:0] mask_one   = `PIFP_DIV1_MASK_TOP >> (`PIFP_DIV1_CODE_TOP - divider_set_one);
  wire [11:0] mask_two   = `PIFP_DIV2_MASK_TOP >> (`PIFP_DIV23_CODE_TOP - divider_set_two);
  wire [6:0]  mask_three = `PIFP_DIV3_MASK_TOP >> (`PIFP_DIV23_CODE_TOP - divider_set_three);

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_cnt_q <= 12'h000;
      lpo_cnt_q <= 7'h00;
    end else begin
      bus_cnt_q <= bus_cnt_q + 12'h001;
      if (lpo_rise) begin
        lpo_cnt_q <= lpo_cnt_q + 7'h01;
      end
    end
  end

  wire tick_one   = ((bus_cnt_q & mask_one) == mask_one);
  wire tick_two   = ((bus_cnt_q & mask_two) == mask_two);
  // set three counts edges of the sampled low-power clock
  // lpo is sampled as data, so it must run well below half the bus clock
  wire tick_three = lpo_rise & ((lpo_cnt_q & mask_three) == mask_three);

  // select 00 ticks every clock, so every filter but the bypassed reset/irq one still needs two bus clocks
  function pick_tick;
    input [1:0] sel;
    input       t1;
    input       t2;
    input       t3;
    begin
      case (sel)
        `PIFP_FSEL_BUS:  pick_tick = 1'b1;
        `PIFP_FSEL_DIV1: pick_tick = t1;
        `PIFP_FSEL_DIV2: pick_tick = t2;
        `PIFP_FSEL_DIV3: pick_tick = t3;
        default:         pick_tick = 1'b1;
      endcase
    end
  endfunction

  // only the keyboard and reset/irq filters follow stop mode; the port
  // filters keep their own choice
  // stop mode pushes the set-one and set-two choices to set three
  function [1:0] stop_sel;
    input [1:0] sel;
    input       stop;
    begin
      if (stop && (sel == `PIFP_FSEL_DIV1 || sel == `PIFP_FSEL_DIV2)) begin
        stop_sel = `PIFP_FSEL_DIV3;
      end else begin
        stop_sel = sel;
      end
    end
  endfunction

  wire [1:0] kb_eff  = stop_sel(keyboard_irq_filter_sel, stop_mode_in);
  wire [1:0] rst_eff = stop_sel(reset_irq_pin_filter_sel, stop_mode_in);

  wire tick_pa  = pick_tick(port_a_filter_sel, tick_one, tick_two, tick_three);
  wire tick_pb  = pick_tick(port_b_filter_sel, tick_one, tick_two, tick_three);
  wire tick_pc  = pick_tick(port_c_filter_sel, tick_one, tick_two, tick_three);
  wire tick_kb  = pick_tick(kb_eff, tick_one, tick_two, tick_three);
  wire tick_rst = pick_tick(rst_eff, tick_one, tick_two, tick_three);
  wire rst_bypass = (rst_eff == `PIFP_FSEL_BUS);

  wire [5:0] pa_filt;
  wire [7:0] pb_filt;
  wire [3:0] pc_filt;
  wire       kb_filt;
  wire       rst_filt;

  // port filters never bypass; only the reset/irq pin may run unfiltered
  pifp_filter #(.WIDTH(6), .INIT(6'h00)) u_filt_pa (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .din_in      (pa_sync),
    .tick_in     (tick_pa),
    .bypass_in   (1'b0),
    .dout_out    (pa_filt)
  );

  pifp_filter #(.WIDTH(8), .INIT(8'h00)) u_filt_pb (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .din_in      (pb_sync),
    .tick_in     (tick_pb),
    .bypass_in   (1'b0),
    .dout_out    (pb_filt)
  );

  pifp_filter #(.WIDTH(4), .INIT(4'h0)) u_filt_pc (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .din_in      (pc_sync),
    .tick_in     (tick_pc),
    .bypass_in   (1'b0),
    .dout_out    (pc_filt)
  );

  pifp_filter #(.WIDTH(1), .INIT(1'b0)) u_filt_kb (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .din_in      (kbi_sync),
    .tick_in     (tick_kb),
    .bypass_in   (1'b0),
    .dout_out    (kb_filt)
  );

  // reset pin idles high, so its filter starts high to avoid a false edge
  pifp_filter #(.WIDTH(1), .INIT(1'b1)) u_filt_rst (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .din_in      (rst_sync),
    .tick_in     (tick_rst),
    .bypass_in   (rst_bypass),
    .dout_out    (rst_filt)
  );

  // outputs
  // filtered levels leave straight from the filter registers; port c passes its enable gate first
  assign port_a_in_out       = pa_filt;
  assign port_b_in_out       = pb_filt;
  // a disabled port c input reads low whatever the pin does
  assign port_c_in_out       = pc_filt & port_c_input_enable_q;
  assign port_c_in_en_out    = port_c_input_enable_q;
  assign keyboard_irq_in_out = kb_filt;
  assign reset_irq_in_out    = rst_filt;
  // pull-up only for a pin that is a plain input, never output or hi-z
  assign port_a_pull_out     = port_a_pullup_enable_q & ~port_a_out_en_in
                               & port_a_in_en_in;

endmodule // pifp_top

// ---- tb/pifp_top_properties.sv ----
`timescale 1ns/100ps
`include "pifp_defines.vh"
module pifp_chk (
  input wire                    core_clk_in,
  input wire                    rst_in,
  input wire                    psel_in,
  input wire                    penable_in,
  input wire                    pwrite_in,
  input wire [`PIFP_ADDR_W-1:0] paddr_in,
  input wire [31:0]             pwdata_in,
  input wire [3:0]              pstrb_in,
  input wire [31:0]             prdata_out,
  input wire [3:0]              port_c_in_out,
  input wire [3:0]              port_c_in_en_out,
  input wire [5:0]              port_a_pull_out,
  input wire [5:0]              port_a_out_en_in,
  input wire [5:0]              port_a_in_en_in
);
  localparam logic [17:0] A_PCIE = {`PIFP_IDX_PORT_C_INPUT_ENABLE, 2'b00};
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_rd;
    psel_in && penable_in && !pwrite_in;
  endsequence
  sequence s_wr_pcie;
    psel_in && penable_in && pwrite_in && pstrb_in[0] && paddr_in == A_PCIE;
  endsequence
  a_c_gate: assert property ((port_c_in_out & ~port_c_in_en_out) == 4'h0)
    else $error("port c input passed while disabled");
  a_c_write: assert property (s_wr_pcie |=> port_c_in_en_out == $past(pwdata_in[3:0]))
    else $error("port c enable not written");
  a_c_hold: assert property (!(psel_in && penable_in && pwrite_in) |=> $stable(port_c_in_en_out))
    else $error("port c enable changed without write");
  a_rd_upper: assert property (s_rd |-> prdata_out[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_c_resv: assert property ((s_rd ##0 (paddr_in == A_PCIE)) |-> prdata_out[7:0] == {4'h0, port_c_in_en_out})
    else $error("port c enable readback wrong");
  a_pull_resv: assert property (port_a_pull_out[4] == 1'b0)
    else $error("reserved pull bit active");
  a_pull_oe: assert property ((port_a_pull_out & port_a_out_en_in) == 6'h00)
    else $error("pull-up on output pin");
  a_pull_ie: assert property ((port_a_pull_out & ~port_a_in_en_in) == 6'h00)
    else $error("pull-up on high impedance pin");
endmodule // pifp_chk

bind pifp_top pifp_chk u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pstrb_in(pstrb_in), .prdata_out(prdata_out), .port_c_in_out(port_c_in_out),
  .port_c_in_en_out(port_c_in_en_out), .port_a_pull_out(port_a_pull_out),
  .port_a_out_en_in(port_a_out_en_in), .port_a_in_en_in(port_a_in_en_in));

// ---- tb/pifp_pin_model.sv ----
`timescale 1ns/100ps
module pifp_pin_model #(
  parameter int LPO_HALF = 40
) (
  input  wire        core_clk_in,
  output logic       lpo_clk_out,
  output logic [5:0] port_a_out,
  output logic [7:0] port_b_out,
  output logic [3:0] port_c_out,
  output logic       kbi_out,
  output logic       reset_irq_out
);
  initial begin
    lpo_clk_out = 1'b0;
    {port_a_out, port_b_out, port_c_out, kbi_out, reset_irq_out} = 20'h00001;
  end
  // free-running oscillator, phase unrelated to the bus clock
  always #(LPO_HALF) lpo_clk_out = ~lpo_clk_out;
  // reset/irq pin idles high like a pulled-up pin, so its pulse goes low
  task automatic drive_pulse(input int w);
    @(posedge core_clk_in);
    {port_a_out, port_b_out, port_c_out, kbi_out, reset_irq_out} <= 20'hffffe;
    repeat (w) @(posedge core_clk_in);
    {port_a_out, port_b_out, port_c_out, kbi_out, reset_irq_out} <= 20'h00001;
  endtask
endmodule // pifp_pin_model

// ---- tb/pifp_top_tb.sv ----
`timescale 1ns/100ps
`include "pifp_defines.vh"
`define PIFP_CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", what, exp, got); end end
module pifp_top_tb;
  localparam logic [17:0] A_PCIE = {`PIFP_IDX_PORT_C_INPUT_ENABLE, 2'b00};
  localparam logic [17:0] A_PORT = {`PIFP_IDX_PORT_FILTER_SELECT_PORTS, 2'b00};
  localparam logic [17:0] A_DIV  = {`PIFP_IDX_FILTER_CLOCK_DIVIDER, 2'b00};
  localparam logic [17:0] A_SPEC = {`PIFP_IDX_PORT_FILTER_SELECT_SPECIAL, 2'b00};
  localparam logic [17:0] A_PULL = {`PIFP_IDX_PORT_A_PULLUP_ENABLE, 2'b00};
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = '0;
  logic [5:0]  a_oe = '0, a_ie = '0;
  wire  [31:0] prdata;
  wire         pready, pslverr, lpo, kbi_pin, rst_pin, kbi_o, rst_o;
  wire  [5:0]  a_pin, a_o, pull;
  wire  [7:0]  b_pin, b_o;
  wire  [3:0]  c_pin, c_o, c_en;
  int          bad_count = 0, n_checks = 0;
  always #5 clk = ~clk;
  pifp_pin_model pins (.core_clk_in(clk), .lpo_clk_out(lpo), .port_a_out(a_pin),
    .port_b_out(b_pin), .port_c_out(c_pin), .kbi_out(kbi_pin), .reset_irq_out(rst_pin));
  pifp_top dut (.core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .stop_mode_in(stop),
    .lpo_clk_in(lpo), .port_a_pin_in(a_pin), .port_b_pin_in(b_pin), .port_c_pin_in(c_pin),
    .kbi_pin_in(kbi_pin), .reset_irq_pin_in(rst_pin), .port_a_out_en_in(a_oe),
    .port_a_in_en_in(a_ie), .port_a_in_out(a_o), .port_b_in_out(b_o), .port_c_in_out(c_o),
    .keyboard_irq_in_out(kbi_o), .reset_irq_in_out(rst_o), .port_c_in_en_out(c_en),
    .port_a_pull_out(pull));
  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d}; pstrb <= 4'h1;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin bad_count++; report_and_stop(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic regs_case();
    logic [17:0] ra [5] = '{A_PCIE, A_PORT, A_DIV, A_SPEC, A_PULL};
    logic [7:0]  rm [5] = '{8'h0f, 8'h3f, 8'hff, 8'h0f, 8'h2f};
    logic [31:0] rd;
    logic        e;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ra[i], 8'h00, rd, e);
      `PIFP_CHK("reset value", 32'h0, rd)
      apb(1'b1, ra[i], 8'hff, rd, e);
      apb(1'b0, ra[i], 8'h00, rd, e);
      `PIFP_CHK("readback", {24'h0, rm[i]}, rd)
    end
    apb(1'b0, 18'h0c3bc, 8'h00, rd, e);
    `PIFP_CHK("unmapped error", 1'b1, e)
  endtask
  task automatic pull_case();
    a_ie <= 6'h3f; a_oe <= 6'h03;
    @(posedge clk);
    `PIFP_CHK("pull with outputs", 6'h2c, pull)
    a_ie <= 6'h0f; a_oe <= 6'h00;
    @(posedge clk);
    `PIFP_CHK("pull with hi-z", 6'h0f, pull)
  endtask
  // seen bits: any a, any b, c[3:0], kbi, reset pin low
  task automatic pulse_case(input logic [7:0] ports, spec, div, input logic st, input int w,
                            input logic [7:0] exp);
    logic [31:0] rd;
    logic        e;
    logic [7:0]  seen;
    apb(1'b1, A_PORT, ports, rd, e);
    apb(1'b1, A_SPEC, spec, rd, e);
    apb(1'b1, A_DIV, div, rd, e);
    stop <= st;
    seen = '0;
    fork
      pins.drive_pulse(w);
      repeat (w + 200) begin @(posedge clk); seen |= {|a_o, |b_o, c_o, kbi_o, ~rst_o}; end
    join
    `PIFP_CHK("pulse response", exp, seen)
    stop <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `PIFP_CHK("reset pin idle", 1'b1, rst_o)
    regs_case();
    pull_case();
    pulse_case(8'h00, 8'h00, 8'h00, 1'b0, 1, 8'h01);
    pulse_case(8'h00, 8'h00, 8'h00, 1'b0, 10, 8'hff);
    pulse_case(8'h15, 8'h05, 8'h03, 1'b0, 8, 8'h00);
    pulse_case(8'h15, 8'h05, 8'h03, 1'b0, 40, 8'hff);
    pulse_case(8'h2a, 8'h0a, 8'h00, 1'b0, 20, 8'h00);
    pulse_case(8'h2a, 8'h0a, 8'h00, 1'b0, 80, 8'hff);
    pulse_case(8'h2a, 8'h0a, 8'h04, 1'b0, 60, 8'h00);
    pulse_case(8'h3f, 8'h0f, 8'h00, 1'b0, 4, 8'h00);
    pulse_case(8'h3f, 8'h0f, 8'h00, 1'b0, 40, 8'hff);
    pulse_case(8'h00, 8'h05, 8'he3, 1'b1, 40, 8'hfc);
    pulse_case(8'h00, 8'h0a, 8'he0, 1'b1, 80, 8'hfc);
    begin
      logic [31:0] rd;
      logic        e;
      apb(1'b1, A_PCIE, 8'h05, rd, e);
      pulse_case(8'h00, 8'h00, 8'h00, 1'b0, 10, 8'hd7);
    end
    report_and_stop();
  end
endmodule // pifp_top_tb
